/* rtl/aux_sensor_heater_config_regs.sv */
// How it works
// - Aux config bit 6 high selects non-blocking aux conversions, low selects blocking.
// - Aux config bit 5 controls thermistor correction of aux results.
// - Aux config bit 4 high picks fast, noisier ADC conversion; low is normal.
// - Aux config bit 2 high buffers both analog inputs; low leaves them unbuffered.
// - Aux config bit 1 picks internal reference (0) or analog supply (1).
// - Aux config bit 0 drives the dual-function pin low (0) or high (1).
// - Aux config resets to 0000100 above bit 0; bit 0 takes the strap level.
// - Heater level register resets to all zeros, the lowest current.
// - Heater level is four low bits; larger code means more current.
// - Heater runs only while heater_on is set; level only picks current.
// - Reserved bits read fixed values and ignore writes; host writes them back.
// - Dual-function pin is sampled at power-up as the bus address LSB.
`timescale 1ns/100ps
module aux_sensor_heater_config_regs
	import aux_cfg_pkg::*;
#(
	parameter int unsigned ADDR_W = 4,
	parameter int unsigned RESULT_W = 16
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic clock_enable_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [ADDR_W-1:0] awaddr_in,
	input wire logic wvalid_in,
	output logic wready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	output logic bvalid_out,
	input wire logic bready_in,
	output logic [1:0] bresp_out,
	input wire logic arvalid_in,
	output logic arready_out,
	input wire logic [ADDR_W-1:0] araddr_in,
	output logic rvalid_out,
	input wire logic rready_in,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	input wire logic address_strap_output_pin_in,
	output logic address_strap_output_pin_out,
	output logic address_strap_output_pin_oe_out,
	input wire logic supply_sense_input_in,
	input wire logic internal_measure_request_in,
	input wire logic aux_result_valid_in,
	input wire logic [RESULT_W-1:0] aux_raw_result_in,
	input wire logic [RESULT_W-1:0] aux_corrected_result_in,
	output logic aux_result_valid_out,
	output logic [RESULT_W-1:0] aux_result_out,
	output logic non_blocking_mode_out,
	output logic thermistor_correction_enable_out,
	output logic fast_conversion_select_out,
	output logic input_buffer_enable_out,
	output logic reference_source_select_out,
	output logic heater_drive_enable_out,
	output logic [HEATER_CODE_W-1:0] heater_current_code_out,
	output logic device_address_lsb_out,
	output logic core_reset_hold_out
);

	function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		merge_byte = (old_v & ~mask) | (new_v & mask);
	endfunction

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [3:0] off);
		reg_hit = (addr == ADDR_W'(off));
	endfunction

	logic ce;
	assign ce = clock_enable_in;

	// Pin inputs are asynchronous to the bus clock
	logic strap_sync;
	logic sense_sync;
	pin_synchronizer #(
		.WIDTH(2)
	) u_pin_sync (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.enable_in(ce),
		.async_in({address_strap_output_pin_in, supply_sense_input_in}),
		.sync_out({strap_sync, sense_sync})
	);

	power_state_t pwr_r;
	power_state_t pwr_nxt;
	logic [1:0] settle_cnt_r;
	logic strap_r;
	logic [7:0] aux_r;
	logic [7:0] heater_r;
	logic [7:0] ctrl_r;
	logic conflict_r;

	logic run;
	logic strap_capture;
	assign run = (pwr_r == PWR_RUN);
	assign strap_capture = (pwr_r == PWR_STRAP) && (settle_cnt_r == STRAP_SETTLE);

	always_comb begin
		pwr_nxt = pwr_r;
		unique case (pwr_r)
			PWR_STRAP: pwr_nxt = strap_capture ? PWR_SENSE : PWR_STRAP;
			PWR_SENSE: pwr_nxt = sense_sync ? PWR_RUN : PWR_HELD;
			PWR_HELD: pwr_nxt = sense_sync ? PWR_RUN : PWR_HELD;
			PWR_RUN: pwr_nxt = PWR_RUN;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			pwr_r <= PWR_STRAP;
			settle_cnt_r <= '0;
			strap_r <= 1'b0;
		end else if (ce) begin
			pwr_r <= pwr_nxt;
			if (pwr_r == PWR_STRAP && !strap_capture) begin
				settle_cnt_r <= settle_cnt_r + 2'h1;
			end
			if (strap_capture) begin
				strap_r <= strap_sync;
			end
		end
	end

	// Write channel: address and data are caught independently
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [7:0] wdata_r;
	logic wstrb0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	assign awready_out = !aw_held_r && !bvalid_r;
	assign wready_out = !w_held_r && !bvalid_r;

	logic aw_fire;
	logic w_fire;
	logic wr_do;
	logic wr_aux;
	logic wr_heater;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mapped;
	logic wr_ok;
	assign aw_fire = awvalid_in && awready_out;
	assign w_fire = wvalid_in && wready_out;
	assign wr_do = aw_held_r && w_held_r && !bvalid_r;
	assign wr_aux = reg_hit(aw_addr_r, OFF_AUX);
	assign wr_heater = reg_hit(aw_addr_r, OFF_HEATER);
	assign wr_ctrl = reg_hit(aw_addr_r, OFF_CONTROL);
	assign wr_status = reg_hit(aw_addr_r, OFF_STATUS);
	assign wr_mapped = wr_aux || wr_heater || wr_ctrl || wr_status;
	// Writes are refused while the strap and supply checks are pending
	assign wr_ok = wr_do && wr_mapped && run && wstrb0_r;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (aw_fire) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= awaddr_in;
			end
			if (w_fire) begin
				w_held_r <= 1'b1;
				wdata_r <= wdata_in[7:0];
				wstrb0_r <= wstrb_in[0];
			end
			if (wr_do) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wr_mapped && run) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && bready_in) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign bvalid_out = bvalid_r;
	assign bresp_out = bresp_r;

	// Register file; reserved bits sit outside the write masks
	logic [7:0] aux_nxt;
	logic [7:0] heater_nxt;
	logic conflict_set;
	logic conflict_nxt;
	assign aux_nxt = merge_byte(aux_r, wdata_r, AUX_WR_MASK);
	assign heater_nxt = merge_byte(heater_r, wdata_r, HEATER_WR_MASK);
	// Internal run with aux mode bits still set is flagged for software
	assign conflict_set = internal_measure_request_in
		&& (aux_r[AUX_NO_HOLD_BIT] || aux_r[AUX_CORR_BIT]);
	// A new event wins over a clear in the same cycle
	assign conflict_nxt = conflict_set
		|| (conflict_r && !(wr_ok && wr_status && wdata_r[STAT_CONFLICT_BIT]));

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			aux_r <= AUX_RESET;
			heater_r <= HEATER_RESET;
			ctrl_r <= CTRL_RESET;
			conflict_r <= 1'b0;
		end else if (ce) begin
			if (strap_capture) begin
				aux_r[AUX_DRIVE_BIT] <= strap_sync;
			end else if (wr_ok && wr_aux) begin
				aux_r <= aux_nxt;
			end
			if (wr_ok && wr_heater) begin
				heater_r <= heater_nxt;
			end
			if (wr_ok && wr_ctrl) begin
				ctrl_r[CTRL_HEATER_ON_BIT] <= wdata_r[CTRL_HEATER_ON_BIT];
			end
			conflict_r <= conflict_nxt;
		end
	end

	// Read channel: one read outstanding, data the cycle after acceptance
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic ar_fire;
	logic rd_aux;
	logic rd_heater;
	logic rd_ctrl;
	logic rd_status;
	logic [7:0] status_view;
	logic [7:0] rd_byte;
	assign arready_out = !rvalid_r;
	assign ar_fire = arvalid_in && arready_out;
	assign rd_aux = reg_hit(araddr_in, OFF_AUX);
	assign rd_heater = reg_hit(araddr_in, OFF_HEATER);
	assign rd_ctrl = reg_hit(araddr_in, OFF_CONTROL);
	assign rd_status = reg_hit(araddr_in, OFF_STATUS);
	assign status_view = {5'h00, conflict_r, !run, strap_r};
	assign rd_byte = rd_aux ? aux_r :
		rd_heater ? heater_r :
		rd_ctrl ? ctrl_r :
		rd_status ? status_view : 8'h00;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				rvalid_r <= 1'b1;
				rdata_r <= {24'h000000, rd_byte};
				rresp_r <= (rd_aux || rd_heater || rd_ctrl || rd_status) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && rready_in) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign rvalid_out = rvalid_r;
	assign rdata_out = rdata_r;
	assign rresp_out = rresp_r;

	// Aux result path; selection by the correction bit
	logic [RESULT_W-1:0] aux_sel;
	logic aux_valid_r;
	logic [RESULT_W-1:0] aux_result_r;
	assign aux_sel = aux_r[AUX_CORR_BIT] ? aux_corrected_result_in : aux_raw_result_in;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			aux_valid_r <= 1'b0;
			aux_result_r <= '0;
		end else if (ce) begin
			aux_valid_r <= aux_result_valid_in;
			if (aux_result_valid_in) begin
				aux_result_r <= aux_sel;
			end
		end
	end

	assign aux_result_valid_out = aux_valid_r;
	assign aux_result_out = aux_result_r;

	assign non_blocking_mode_out = aux_r[AUX_NO_HOLD_BIT];
	assign thermistor_correction_enable_out = aux_r[AUX_CORR_BIT];
	assign fast_conversion_select_out = aux_r[AUX_FAST_BIT];
	assign input_buffer_enable_out = aux_r[AUX_BUF_BIT];
	assign reference_source_select_out = aux_r[AUX_REF_BIT];
	// Pin stays an input until run, after the strap is taken and supply seen, to avoid fighting the tie
	assign address_strap_output_pin_out = aux_r[AUX_DRIVE_BIT];
	assign address_strap_output_pin_oe_out = run;
	assign heater_drive_enable_out = run && ctrl_r[CTRL_HEATER_ON_BIT];
	assign heater_current_code_out = heater_r[HEATER_CODE_LSB +: HEATER_CODE_W];
	assign device_address_lsb_out = strap_r;
	assign core_reset_hold_out = !run;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in || !ce);

	sequence s_aux_write;
		wr_ok && wr_aux;
	endsequence
	sequence s_strap_taken;
		strap_capture ##1 (pwr_r == PWR_SENSE);
	endsequence
	property p_mode_write;
		s_aux_write |=> non_blocking_mode_out == $past(wdata_r[AUX_NO_HOLD_BIT]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode bit not written");
	property p_conflict;
		conflict_set |=> conflict_r;
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict flag lost");
	property p_result_sel;
		aux_result_valid_in |=> aux_result_valid_out && aux_result_out ==
			($past(aux_r[AUX_CORR_BIT]) ? $past(aux_corrected_result_in) : $past(aux_raw_result_in));
	endproperty
	a_result_sel: assert property (p_result_sel) else $error("wrong aux result");
	property p_fields_write;
		s_aux_write |=> {fast_conversion_select_out, input_buffer_enable_out,
			reference_source_select_out} == {$past(wdata_r[AUX_FAST_BIT]),
			$past(wdata_r[AUX_BUF_BIT]), $past(wdata_r[AUX_REF_BIT])};
	endproperty
	a_fields_write: assert property (p_fields_write) else $error("aux field not written");
	property p_pin_level;
		s_aux_write |=> address_strap_output_pin_oe_out
			&& address_strap_output_pin_out == $past(wdata_r[AUX_DRIVE_BIT]);
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin level mismatch");
	property p_aux_reset;
		s_strap_taken |=> aux_r[7:1] == AUX_RESET[7:1] && aux_r[AUX_DRIVE_BIT] == strap_r;
	endproperty
	a_aux_reset: assert property (p_aux_reset) else $error("aux reset value wrong");
	property p_heater_reset;
		(pwr_r == PWR_STRAP) |-> heater_r == HEATER_RESET;
	endproperty
	a_heater_reset: assert property (p_heater_reset) else $error("heater not reset");
	property p_heater_gate;
		wr_ok && wr_ctrl |=> heater_drive_enable_out == $past(wdata_r[CTRL_HEATER_ON_BIT]);
	endproperty
	a_heater_gate: assert property (p_heater_gate) else $error("heater on while off");
	property p_reserved;
		rvalid_out && $rose(rvalid_out) && $past(rd_aux)
			|-> rdata_out[7] == AUX_RESET[7] && rdata_out[3] == AUX_RESET[3];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit changed");
	property p_strap_stable;
		run |-> $stable(device_address_lsb_out);
	endproperty
	a_strap_stable: assert property (p_strap_stable) else $error("address strap moved");
	// Supply may rise in any held cycle, so only the next cycle is bound
	property p_held;
		(pwr_r == PWR_SENSE || pwr_r == PWR_HELD) && !sense_sync |=> core_reset_hold_out;
	endproperty
	a_held: assert property (p_held) else $error("released without supply");
endmodule

/* shared/aux_cfg_pkg.sv */
package aux_cfg_pkg;

	// Register byte offsets on the bus
	localparam logic [3:0] OFF_AUX = 4'h0;
	localparam logic [3:0] OFF_HEATER = 4'h4;
	localparam logic [3:0] OFF_CONTROL = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hC;

	// Auxiliary measurement config fields
	localparam int unsigned AUX_NO_HOLD_BIT = 6;
	localparam int unsigned AUX_CORR_BIT = 5;
	localparam int unsigned AUX_FAST_BIT = 4;
	localparam int unsigned AUX_BUF_BIT = 2;
	localparam int unsigned AUX_REF_BIT = 1;
	localparam int unsigned AUX_DRIVE_BIT = 0;
	localparam logic [7:0] AUX_RESET = 8'h08;
	localparam logic [7:0] AUX_WR_MASK = 8'h77;

	// Heater level register
	localparam logic [7:0] HEATER_RESET = 8'h00;
	localparam logic [7:0] HEATER_WR_MASK = 8'h0F;
	localparam int unsigned HEATER_CODE_LSB = 0;
	localparam int unsigned HEATER_CODE_W = 4;

	// Control and status registers
	localparam int unsigned CTRL_HEATER_ON_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int unsigned STAT_ADDR_LSB_BIT = 0;
	localparam int unsigned STAT_HELD_BIT = 1;
	localparam int unsigned STAT_CONFLICT_BIT = 2;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Cycles the strap pin settles through the synchroniser before capture
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		PWR_STRAP,
		PWR_SENSE,
		PWR_HELD,
		PWR_RUN
	} power_state_t;

endpackage

/* rtl/pin_synchronizer.sv */
`timescale 1ns/100ps
module pin_synchronizer #(
	parameter int unsigned WIDTH = 2
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	// First stage feeds only the second stage
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else if (enable_in) begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
		end
	end

	assign sync_out = stage2_r;

endmodule

/* verif/axi_host_model.sv */
`timescale 1ns/100ps
module axi_host_model (
	input wire logic clock_in,
	output logic awvalid_out,
	output logic [3:0] awaddr_out,
	output logic wvalid_out,
	output logic [31:0] wdata_out,
	output logic [3:0] wstrb_out,
	output logic bready_out,
	output logic arvalid_out,
	output logic [3:0] araddr_out,
	output logic rready_out,
	input wire logic awready_in,
	input wire logic wready_in,
	input wire logic bvalid_in,
	input wire logic [1:0] bresp_in,
	input wire logic arready_in,
	input wire logic rvalid_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in
);
	initial begin
		awvalid_out = 1'b0;
		awaddr_out = 4'h0;
		wvalid_out = 1'b0;
		wdata_out = 32'h0;
		wstrb_out = 4'hF;
		bready_out = 1'b0;
		arvalid_out = 1'b0;
		araddr_out = 4'h0;
		rready_out = 1'b0;
	end

	// Address and data offered together, each released once taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] resp,
		input logic [3:0] s = 4'hF);
		logic aw_pend;
		logic w_pend;
		aw_pend = 1'b1;
		w_pend = 1'b1;
		@(posedge clock_in);
		awvalid_out <= 1'b1;
		awaddr_out <= a;
		wvalid_out <= 1'b1;
		wdata_out <= {24'h0, d};
		wstrb_out <= s;
		bready_out <= 1'b1;
		while (aw_pend || w_pend) begin
			@(posedge clock_in);
			if (aw_pend && awready_in) begin
				aw_pend = 1'b0;
				awvalid_out <= 1'b0;
			end
			if (w_pend && wready_in) begin
				w_pend = 1'b0;
				wvalid_out <= 1'b0;
			end
		end
		while (!bvalid_in) @(posedge clock_in);
		resp = bresp_in;
		bready_out <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clock_in);
		arvalid_out <= 1'b1;
		araddr_out <= a;
		rready_out <= 1'b1;
		do @(posedge clock_in); while (!arready_in);
		arvalid_out <= 1'b0;
		while (!rvalid_in) @(posedge clock_in);
		d = rdata_in;
		resp = rresp_in;
		rready_out <= 1'b0;
	endtask
endmodule

/* verif/aux_sensor_heater_config_regs_bench.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD %0t got %h expected %h", $time, (a), (e)); end end
module aux_sensor_heater_config_regs_bench;
	import aux_cfg_pkg::*;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic supply = 1'b0;
	logic ce = 1'b1;
	logic strap_pull = 1'b1;
	logic meas_req = 1'b0;
	logic res_valid = 1'b0;
	logic [15:0] raw = 16'h1234;
	logic [15:0] corr = 16'hABCD;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, resp;
	logic pin_out, pin_oe, res_drive_output_level, nb, tc, fast, buff, rsel, htr, lsb, hold;
	logic [15:0] res_out;
	logic [3:0] code;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	// Strap resistor level whenever the device is not driving
	wire pin_wire = pin_oe ? pin_out : strap_pull;

	always #5 clock_in = ~clock_in;

	axi_host_model i_host (.clock_in(clock_in), .awvalid_out(awvalid), .awaddr_out(awaddr),
		.wvalid_out(wvalid), .wdata_out(wdata), .wstrb_out(wstrb), .bready_out(bready),
		.arvalid_out(arvalid), .araddr_out(araddr), .rready_out(rready), .awready_in(awready),
		.wready_in(wready), .bvalid_in(bvalid), .bresp_in(bresp), .arready_in(arready),
		.rvalid_in(rvalid), .rdata_in(rdata), .rresp_in(rresp));

	aux_sensor_heater_config_regs i_dut (.clock_in(clock_in), .reset_in(reset_in),
		.clock_enable_in(ce), .awvalid_in(awvalid), .awready_out(awready),
		.awaddr_in(awaddr), .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata),
		.wstrb_in(wstrb), .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
		.arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr), .rvalid_out(rvalid),
		.rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
		.address_strap_output_pin_in(pin_wire), .address_strap_output_pin_out(pin_out),
		.address_strap_output_pin_oe_out(pin_oe), .supply_sense_input_in(supply),
		.internal_measure_request_in(meas_req), .aux_result_valid_in(res_valid),
		.aux_raw_result_in(raw), .aux_corrected_result_in(corr),
		.aux_result_valid_out(res_drive_output_level), .aux_result_out(res_out), .non_blocking_mode_out(nb),
		.thermistor_correction_enable_out(tc), .fast_conversion_select_out(fast),
		.input_buffer_enable_out(buff), .reference_source_select_out(rsel),
		.heater_drive_enable_out(htr), .heater_current_code_out(code),
		.device_address_lsb_out(lsb), .core_reset_hold_out(hold));

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end

	task automatic power_up;
		i_host.wr(OFF_AUX, 8'h7F, resp);
		`CHK(resp, RESP_SLVERR)
		`CHK(hold, 1'b1)
		@(posedge clock_in);
		supply <= 1'b1;
		repeat (8) @(posedge clock_in);
		`CHK(hold, 1'b0)
		i_host.rd(OFF_AUX, d, resp);
		`CHK(d, {24'h0, AUX_RESET[7:1], 1'b1})
		`CHK(lsb, 1'b1)
		i_host.rd(OFF_HEATER, d, resp);
		`CHK(d, {24'h0, HEATER_RESET})
		`CHK({pin_oe, pin_out}, 2'b11)
	endtask

	task automatic field_walk;
		int bits[6] = '{6, 5, 4, 2, 1, 0};
		logic [7:0] v;
		for (int i = 0; i < 6; i++) begin
			v = AUX_RESET | (8'h01 << bits[i]);
			i_host.wr(OFF_AUX, v, resp);
			i_host.rd(OFF_AUX, d, resp);
			`CHK(d, {24'h0, v})
			`CHK({nb, tc, fast, buff, rsel, pin_out}, 6'b100000 >> i)
		end
		i_host.wr(OFF_AUX, 8'hFF, resp);
		i_host.rd(OFF_AUX, d, resp);
		`CHK(d, 32'h7F)
		i_host.wr(OFF_AUX, 8'h00, resp);
		i_host.rd(OFF_AUX, d, resp);
		`CHK(d, {24'h0, AUX_RESET})
		// Low byte strobe off: accepted but nothing lands
		i_host.wr(OFF_AUX, 8'h77, resp, 4'hE);
		`CHK(resp, RESP_OKAY)
		i_host.rd(OFF_AUX, d, resp);
		`CHK(d, {24'h0, AUX_RESET})
	endtask

	// Second power-up with the strap tied low and the clock enable held off
	task automatic restrap;
		@(posedge clock_in);
		reset_in <= 1'b1;
		strap_pull <= 1'b0;
		repeat (3) @(posedge clock_in);
		reset_in <= 1'b0;
		ce <= 1'b0;
		repeat (10) @(posedge clock_in);
		ce <= 1'b1;
		repeat (3) @(posedge clock_in);
		`CHK(hold, 1'b1)
		repeat (8) @(posedge clock_in);
		`CHK(hold, 1'b0)
		`CHK({lsb, pin_oe, pin_out}, 3'b010)
		i_host.rd(OFF_AUX, d, resp);
		`CHK(d, {24'h0, AUX_RESET})
		i_host.rd(OFF_HEATER, d, resp);
		`CHK(d, {24'h0, HEATER_RESET})
	endtask

	task automatic heater;
		logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
		for (int i = 0; i < 6; i++) begin
			i_host.wr(OFF_HEATER, {4'hA, codes[i]}, resp);
			i_host.rd(OFF_HEATER, d, resp);
			`CHK(d, {28'h0, codes[i]})
			`CHK(code, codes[i])
		end
		`CHK(htr, 1'b0)
		i_host.wr(OFF_CONTROL, 8'h01, resp);
		`CHK(htr, 1'b1)
		i_host.wr(OFF_CONTROL, 8'h00, resp);
		`CHK(htr, 1'b0)
	endtask

	task automatic correction;
		int n;
		for (int c = 0; c < 2; c++) begin
			i_host.wr(OFF_AUX, AUX_RESET | (c[0] ? 8'h20 : 8'h00), resp);
			@(posedge clock_in);
			res_valid <= 1'b1;
			@(posedge clock_in);
			res_valid <= 1'b0;
			n = 0;
			do begin
				@(posedge clock_in);
				n++;
			end while (!res_drive_output_level && n < 4);
			`CHK(res_drive_output_level, 1'b1)
			`CHK(res_out, c[0] ? corr : raw)
		end
	endtask

	task automatic measure(input logic [7:0] aux, input logic exp);
		i_host.wr(OFF_AUX, aux, resp);
		i_host.wr(OFF_STATUS, 8'h04, resp);
		@(posedge clock_in);
		meas_req <= 1'b1;
		@(posedge clock_in);
		meas_req <= 1'b0;
		i_host.rd(OFF_STATUS, d, resp);
		`CHK(d[STAT_CONFLICT_BIT], exp)
	endtask

	initial begin
		repeat (3) @(posedge clock_in);
		reset_in <= 1'b0;
		power_up;
		field_walk;
		heater;
		correction;
		measure(AUX_RESET | 8'h40, 1'b1);
		// Host clears both mode bits before an internal run
		measure(AUX_RESET, 1'b0);
		i_host.rd(4'h2, d, resp);
		`CHK({resp, d}, {RESP_SLVERR, 32'h0})
		restrap;
		tally_and_finish;
	end
endmodule
